// [mifc_pkg.sv]
// mifc_pkg: constants, enums and structs for the motor input function control block
// assumes a single 40 MHz clock domain
package mifc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_IN = 5;
    localparam int FUNC_W = 5;
    localparam int IDX_W = 3;

    // ------------------------------------------------------------
    // function codes
    // ------------------------------------------------------------
    localparam logic [4:0] FN_NONE = 5'h00;
    localparam logic [4:0] FN_RUN = 5'h01;
    localparam logic [4:0] FN_DIR = 5'h02;
    localparam logic [4:0] FN_COAST = 5'h05;
    localparam logic [4:0] FN_STOPMODE = 5'h06;
    localparam logic [4:0] FN_COMBINED = 5'h07;
    localparam logic [4:0] FN_ALMCLR = 5'h08;
    localparam logic [4:0] FN_IDX0 = 5'h0A;
    localparam logic [4:0] FN_IDX1 = 5'h0B;
    localparam logic [4:0] FN_IDX2 = 5'h0C;
    localparam logic [4:0] FN_HALT = 5'h0D;
    localparam logic [4:0] FN_PWREN = 5'h0E;
    localparam logic [4:0] FN_STOPREQ = 5'h11;
    localparam logic [4:0] FN_EXTFAULT = 5'h15;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 40000000;
    localparam longint CLR_HOLD_MS = 500;
    // longer than 0.5 s: least time, rounded up
    localparam longint CLR_HOLD_CYC = (CLR_HOLD_MS * CLK_HZ + 999) / 1000;
    localparam int CNT_W = 25;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLR_IDLE = 2'b00,
        CLR_LOW = 2'b01,
        CLR_HIGH = 2'b10,
        CLR_ARMED = 2'b11
    } mifc_clr_state_type;

    typedef enum logic [1:0] {
        MOT_WAIT = 2'b00,
        MOT_STOPPED = 2'b01,
        MOT_RUN = 2'b10,
        MOT_STOPPING = 2'b11
    } mifc_mot_state_type;

    // decoded command set
    typedef struct packed {
        logic run;
        logic dir;
        logic clockwise_run_input;
        logic counterclockwise_run_input;
        logic coast;
        logic stopmode;
        logic combined;
        logic almclr;
        logic halt;
        logic pwren;
        logic stopreq;
        logic extfault;
        logic [2:0] idx;
    } mifc_cmd_type;

    // motor drive command
    typedef struct packed {
        logic power;
        logic run;
        logic ccw;
        logic fast_stop;
        logic brake_release;
    } mifc_drive_type;

endpackage

// [mifc_sync.sv]
// mifc_sync: two-flop synchroniser with active-level option per input
// assumes inputs are asynchronous levels from switches
`timescale 1ns/1ps
`default_nettype none
module mifc_sync
    import mifc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [NUM_IN-1:0] i_pins,
    input wire logic [NUM_IN-1:0] i_open_active,
    output logic [NUM_IN-1:0] o_on
);
    logic [NUM_IN-1:0] meta_q;
    logic [NUM_IN-1:0] sync_q;
    logic [NUM_IN-1:0] on_q;
    wire logic [NUM_IN-1:0] level_d = sync_q ^ i_open_active;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= '0;
            sync_q <= '0;
            on_q <= '0;
        end else begin
            meta_q <= i_pins;
            sync_q <= meta_q;
            on_q <= level_d;
        end
    end

    assign o_on = on_q;
endmodule
`default_nettype wire

// [mifc_clr_seq.sv]
// mifc_clr_seq: timed off-on-off alarm clear sequence detector
// assumes the clear level is already synchronised
`timescale 1ns/1ps
`default_nettype none
module mifc_clr_seq
    import mifc_pkg::*;
#(
    parameter logic [CNT_W-1:0] HOLD_CYC = CNT_W'(CLR_HOLD_CYC)
)
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_enable,
    input wire logic i_level,
    output logic o_clear
);
    mifc_clr_state_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q;
    logic clear_q;
    wire logic held = (cnt_q >= HOLD_CYC);
    wire logic moved = (st_d != st_q);

    always_comb begin
        st_d = st_q;
        case (st_q)
            CLR_IDLE: if (!i_level) st_d = CLR_LOW;
            CLR_LOW: begin
                if (i_level) st_d = held ? CLR_HIGH : CLR_IDLE;
            end
            CLR_HIGH: begin
                if (!i_level) st_d = CLR_IDLE;
                else if (held) st_d = CLR_ARMED;
            end
            CLR_ARMED: if (!i_level) st_d = CLR_IDLE;
            default: st_d = CLR_IDLE;
        endcase
        if (!i_enable) st_d = CLR_IDLE;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= CLR_IDLE;
            cnt_q <= '0;
            clear_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (moved) cnt_q <= '0;
            else if (!held) cnt_q <= cnt_q + 1'b1;
            // off, on, then off completes the sequence
            clear_q <= i_enable && st_q == CLR_ARMED && !i_level;
        end
    end

    assign o_clear = clear_q;
endmodule
`default_nettype wire

// [mifc_top.sv]
// mifc_top: decodes programmable digital inputs into motor commands
// assumes one 40 MHz clock; config and status are plain ports
// Contract
// - each input picks closed or open circuit as its ON state
// - function code 0 gives no control effect
// - single style: run input runs motor, direction input ON means counter-clockwise
// - dual style: forward runs clockwise, reverse counter-clockwise, OFF stops
// - forward and reverse both ON stop motor when conflict option is 1
// - stop-method input ON stops instantly, OFF ramps down
// - coast input cuts motor power and drops the holding brake release output (brake locked)
// - combined input is emergency halt normally, alarm clear while alarmed
// - alarm clears after off over 0.5 s, on over 0.5 s, then off
// - alarm clear ignored while a run command is ON
// - functions 10, 11, 12 are index bits 0, 1, 2
// - emergency halt stops instantly and blocks running until released
// - during emergency halt the holding brake locks once motor stopped
// - power enable OFF cuts power and waits; ON enables servo
// - stop request stops motor by selected method, OFF resumes
// - external fault raises alarm, resettable only while input OFF
// - index bits form data number 0 to 7, bit 2 most significant
`timescale 1ns/1ps
`default_nettype none
module mifc_top
    import mifc_pkg::*;
#(
    parameter logic [CNT_W-1:0] CLR_HOLD = CNT_W'(CLR_HOLD_CYC)
)
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [NUM_IN-1:0] i_pins,
    input wire logic [NUM_IN-1:0] i_open_active,
    input wire logic [NUM_IN*FUNC_W-1:0] i_func_codes,
    input wire logic i_dual_command_style,
    input wire logic i_conflict_stop,
    input wire logic i_motor_stopped,
    input wire logic i_internal_alarm,
    output logic o_power,
    output logic o_run,
    output logic o_ccw,
    output logic o_fast_stop,
    output logic o_holding_brake_output,
    output logic o_servo_wait,
    output logic o_alarm,
    output logic o_ext_alarm,
    output logic [IDX_W-1:0] o_data_index
);
    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] on_lv;

    mifc_sync u_sync (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_pins(i_pins),
        .i_open_active(i_open_active),
        .o_on(on_lv)
    );

    // ------------------------------------------------------------
    // function decode
    // ------------------------------------------------------------
    // OR of every ON input whose function code matches
    function automatic logic any_on(input logic [NUM_IN*FUNC_W-1:0] codes,
                                    input logic [NUM_IN-1:0] lv,
                                    input logic [FUNC_W-1:0] fn);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_IN; k++) begin
            if (codes[k*FUNC_W +: FUNC_W] == fn && fn != FN_NONE) r = r | lv[k];
        end
        return r;
    endfunction

    mifc_cmd_type cmd;
    assign cmd.run = any_on(i_func_codes, on_lv, FN_RUN);
    assign cmd.dir = any_on(i_func_codes, on_lv, FN_DIR);
    assign cmd.clockwise_run_input = cmd.run;
    assign cmd.counterclockwise_run_input = cmd.dir;
    assign cmd.coast = any_on(i_func_codes, on_lv, FN_COAST);
    assign cmd.stopmode = any_on(i_func_codes, on_lv, FN_STOPMODE);
    assign cmd.combined = any_on(i_func_codes, on_lv, FN_COMBINED);
    assign cmd.almclr = any_on(i_func_codes, on_lv, FN_ALMCLR);
    assign cmd.halt = any_on(i_func_codes, on_lv, FN_HALT);
    assign cmd.pwren = any_on(i_func_codes, on_lv, FN_PWREN);
    assign cmd.stopreq = any_on(i_func_codes, on_lv, FN_STOPREQ);
    assign cmd.extfault = any_on(i_func_codes, on_lv, FN_EXTFAULT);
    assign cmd.idx = {any_on(i_func_codes, on_lv, FN_IDX2),
                      any_on(i_func_codes, on_lv, FN_IDX1),
                      any_on(i_func_codes, on_lv, FN_IDX0)};

    // ------------------------------------------------------------
    // alarm handling
    // ------------------------------------------------------------
    logic ext_alarm_q;
    logic alarm_latched_q;
    logic clear_pulse;
    wire logic alarm_any = ext_alarm_q | alarm_latched_q;
    wire logic halt_eff = cmd.halt | (cmd.combined & ~alarm_any);
    wire logic clr_level = cmd.almclr | (cmd.combined & alarm_any);
    wire logic op_cmd = cmd.run | cmd.dir & i_dual_command_style;
    wire logic clr_enable = alarm_any & ~op_cmd & ~cmd.extfault;

    mifc_clr_seq #(
        .HOLD_CYC(CLR_HOLD)
    ) u_clr (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_enable(clr_enable),
        .i_level(clr_level),
        .o_clear(clear_pulse)
    );

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_alarm_q <= 1'b0;
            alarm_latched_q <= 1'b0;
        end else begin
            // set wins over clear
            if (cmd.extfault) ext_alarm_q <= 1'b1;
            else if (clear_pulse) ext_alarm_q <= 1'b0;
            if (i_internal_alarm) alarm_latched_q <= 1'b1;
            else if (clear_pulse) alarm_latched_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // run request and direction
    // ------------------------------------------------------------
    wire logic sc_run = cmd.run;
    wire logic dc_conflict = cmd.clockwise_run_input & cmd.counterclockwise_run_input & i_conflict_stop;
    wire logic dc_run = (cmd.clockwise_run_input | cmd.counterclockwise_run_input) & ~dc_conflict;
    wire logic want_run = i_dual_command_style ? dc_run : sc_run;
    wire logic want_ccw = i_dual_command_style ? (cmd.counterclockwise_run_input & ~cmd.clockwise_run_input) : cmd.dir;
    wire logic inhibit = halt_eff | cmd.stopreq | alarm_any | cmd.coast;
    wire logic run_ok = want_run & ~inhibit & cmd.pwren;

    // ------------------------------------------------------------
    // motor state
    // ------------------------------------------------------------
    mifc_mot_state_type mst_q, mst_d;
    logic fast_q;
    logic ccw_q;

    always_comb begin
        mst_d = mst_q;
        case (mst_q)
            MOT_WAIT: if (cmd.pwren) mst_d = MOT_STOPPED;
            MOT_STOPPED: if (run_ok) mst_d = MOT_RUN;
            MOT_RUN: if (!run_ok) mst_d = MOT_STOPPING;
            MOT_STOPPING: begin
                if (run_ok) mst_d = MOT_RUN;
                else if (i_motor_stopped) mst_d = MOT_STOPPED;
            end
            default: mst_d = MOT_WAIT;
        endcase
        if (!cmd.pwren) mst_d = MOT_WAIT;
    end

    wire logic stop_fast = cmd.stopmode | halt_eff;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mst_q <= MOT_WAIT;
            fast_q <= 1'b0;
            ccw_q <= 1'b0;
        end else begin
            mst_q <= mst_d;
            fast_q <= stop_fast;
            if (run_ok) ccw_q <= want_ccw;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    mifc_drive_type drv_q;
    logic [IDX_W-1:0] idx_q;
    wire logic running = (mst_q == MOT_RUN);
    wire logic powered = (mst_q != MOT_WAIT) & ~cmd.coast;
    // brake released while powered, locked under halt once stopped
    wire logic brake_rel = powered & ~(halt_eff & i_motor_stopped);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            drv_q <= '0;
            idx_q <= '0;
        end else begin
            drv_q.power <= powered;
            drv_q.run <= running & ~cmd.coast;
            drv_q.ccw <= ccw_q;
            drv_q.fast_stop <= fast_q;
            drv_q.brake_release <= brake_rel;
            idx_q <= cmd.idx;
        end
    end

    assign o_power = drv_q.power;
    assign o_run = drv_q.run;
    assign o_ccw = drv_q.ccw;
    assign o_fast_stop = drv_q.fast_stop;
    assign o_holding_brake_output = drv_q.brake_release;
    assign o_servo_wait = (mst_q == MOT_WAIT);
    assign o_alarm = alarm_any;
    assign o_ext_alarm = ext_alarm_q;
    assign o_data_index = idx_q;
endmodule
`default_nettype wire

// [mifc_checker.sv]
// mifc_checker: concurrent checks on the input function control top ports
// assumes one clock domain and a bind from the bench
`timescale 1ns/1ps
`default_nettype none
module mifc_checker
    import mifc_pkg::*;
#(
    parameter logic [CNT_W-1:0] CLR_HOLD = CNT_W'(CLR_HOLD_CYC)
)
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [NUM_IN-1:0] i_pins,
    input wire logic [NUM_IN-1:0] i_open_active,
    input wire logic [NUM_IN*FUNC_W-1:0] i_func_codes,
    input wire logic o_power,
    input wire logic o_run,
    input wire logic o_servo_wait,
    input wire logic o_alarm,
    input wire logic o_ext_alarm,
    input wire logic [IDX_W-1:0] o_data_index
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    logic [CNT_W-1:0] age_q;
    // cycles spent with an alarm standing
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) age_q <= '0;
        else if (!o_alarm) age_q <= '0;
        else if (age_q != '1) age_q <= age_q + 1'b1;
    end
    property p_alarm_or; o_ext_alarm |-> o_alarm; endproperty
    a_alarm_or: assert property (p_alarm_or)
        else $error("ext alarm without alarm");
    property p_run_power; o_run |-> o_power; endproperty
    a_run_power: assert property (p_run_power)
        else $error("run without power");
    property p_no_run_alarm; $rose(o_run) |-> !$past(o_alarm); endproperty
    a_no_run_alarm: assert property (p_no_run_alarm)
        else $error("run started under alarm");
    property p_wait_no_run; o_servo_wait && $past(o_servo_wait) |-> !o_run; endproperty
    a_wait_no_run: assert property (p_wait_no_run)
        else $error("run in wait state");
    property p_reset_wait; $rose(i_rstn) |-> o_servo_wait && !o_power; endproperty
    a_reset_wait: assert property (p_reset_wait)
        else $error("bad state after reset");
    property p_clear_time; $fell(o_alarm) |-> $past(age_q) >= CLR_HOLD; endproperty
    a_clear_time: assert property (p_clear_time)
        else $error("alarm cleared too soon");
    property p_alarm_hold; $rose(o_alarm) |-> o_alarm [*8]; endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm did not latch");
    property p_index_stable;
        ($stable(i_pins) && $stable(i_open_active) && $stable(i_func_codes)) [*6]
            |=> $stable(o_data_index);
    endproperty
    a_index_stable: assert property (p_index_stable)
        else $error("index moved with inputs still");
endmodule
`default_nettype wire

// [mifc_switches.sv]
// mifc_switches: external switches and a motor that coasts to rest
// assumes the bench gives the wanted ON levels
`timescale 1ns/1ps
`default_nettype none
module mifc_switches (
    input wire logic i_mclk,
    input wire logic [4:0] i_on,
    input wire logic [4:0] i_open_active,
    input wire logic i_run,
    output logic [4:0] o_pins,
    output logic o_motor_stopped
);
    logic [2:0] spin_q = 3'h0;
    assign o_pins = i_on ^ i_open_active;
    assign o_motor_stopped = (spin_q == 3'h0);
    always_ff @(posedge i_mclk) begin
        spin_q <= {spin_q[1:0], i_run};
    end
endmodule
`default_nettype wire

// [mifc_top_tb.sv]
// mifc_top_tb: scenario bench for the input function control block
// assumes the switch model and checker files compile first
`timescale 1ns/1ps
`default_nettype none
module mifc_top_tb;
    import mifc_pkg::*;
    localparam logic [CNT_W-1:0] HOLD = 25'h0000010;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] on = 5'h00;
    logic [4:0] oa = 5'h00;
    logic [24:0] fc = 25'h0000000;
    logic dual = 1'b0;
    logic cstop = 1'b0;
    logic ialm = 1'b0;
    wire logic [4:0] pins;
    wire logic stopped;
    wire logic pw, run, ccw, fst, brk, swait, alm, ealm;
    wire logic [2:0] idx;
    int failures = 0;
    int check_count = 0;
    mifc_switches sw_u (.i_mclk(mclk), .i_on(on), .i_open_active(oa), .i_run(run),
        .o_pins(pins), .o_motor_stopped(stopped));
    mifc_top #(.CLR_HOLD(HOLD)) dut_u (.i_mclk(mclk), .i_rstn(rstn), .i_pins(pins),
        .i_open_active(oa), .i_func_codes(fc), .i_dual_command_style(dual),
        .i_conflict_stop(cstop), .i_motor_stopped(stopped), .i_internal_alarm(ialm),
        .o_power(pw), .o_run(run), .o_ccw(ccw), .o_fast_stop(fst),
        .o_holding_brake_output(brk), .o_servo_wait(swait), .o_alarm(alm),
        .o_ext_alarm(ealm), .o_data_index(idx));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] expv, input string what);
        check_count++;
        if (got !== expv) begin
            failures++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, expv);
        end
    endtask
    task automatic drive(input logic [4:0] v);
        @(negedge mclk);
        on = v;
        repeat (12) @(negedge mclk);
    endtask
    task automatic reset_dut();
        @(negedge mclk);
        rstn = 1'b0;
        on = 5'h00;
        oa = 5'h00;
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
    endtask
    // clear input off, on, off with the given other inputs held
    task automatic seq(input logic [4:0] base);
        drive(base);
        repeat (24) @(negedge mclk);
        on = base | 5'h04;
        repeat (24) @(negedge mclk);
        drive(base);
    endtask
    task automatic t_reset();
        fc = 25'h0000000;
        reset_dut();
        chk({pw, run, swait, alm}, 4'h2, "reset values");
        drive(5'h1F);
        chk({pw, run, swait, alm}, 4'h2, "code zero");
        $display("t_reset done");
    endtask
    task automatic t_single();
        reset_dut();
        fc = {FN_STOPREQ, FN_STOPMODE, FN_DIR, FN_RUN, FN_PWREN};
        drive(5'h07);
        chk({pw, run, ccw, swait}, 4'hE, "run ccw");
        drive(5'h03);
        chk({pw, run, ccw, swait}, 4'hC, "run cw");
        drive(5'h1B);
        chk({pw, run, fst, alm}, 4'hA, "fast stop");
        drive(5'h03);
        chk({2'h0, pw, run}, 4'h3, "resume");
        drive(5'h13);
        chk({pw, run, fst, alm}, 4'h8, "ramp stop");
        drive(5'h02);
        chk({pw, run, swait, alm}, 4'h2, "power off");
        $display("t_single done");
    endtask
    task automatic t_dual();
        reset_dut();
        dual = 1'b1;
        cstop = 1'b1;
        fc = {FN_NONE, FN_COAST, FN_DIR, FN_RUN, FN_PWREN};
        drive(5'h03);
        chk({1'b0, pw, run, ccw}, 4'h6, "forward");
        drive(5'h05);
        chk({1'b0, pw, run, ccw}, 4'h7, "reverse");
        drive(5'h07);
        chk({2'h0, pw, run}, 4'h2, "both on");
        drive(5'h0B);
        chk({pw, run, brk, alm}, 4'h0, "coast");
        dual = 1'b0;
        cstop = 1'b0;
        $display("t_dual done");
    endtask
    task automatic t_index();
        reset_dut();
        fc = {FN_IDX2, FN_IDX1, FN_IDX0, FN_NONE, FN_NONE};
        for (int v = 0; v < 8; v++) begin
            oa = 5'(v << 1);
            drive(5'(v << 2));
            chk({1'b0, idx}, 4'(v), "index");
        end
        $display("t_index done");
    endtask
    task automatic t_halt();
        reset_dut();
        fc = {FN_NONE, FN_NONE, FN_HALT, FN_RUN, FN_PWREN};
        drive(5'h03);
        drive(5'h07);
        chk({1'b0, run, fst, brk}, 4'h2, "halt");
        drive(5'h03);
        chk({1'b0, pw, run, brk}, 4'h7, "halt released");
        $display("t_halt done");
    endtask
    task automatic t_alarm(input logic [4:0] code, input logic ext);
        reset_dut();
        fc = {FN_NONE, FN_EXTFAULT, code, FN_RUN, FN_PWREN};
        drive(5'h07);
        chk({2'h0, pw, run}, {3'h1, code == FN_ALMCLR}, "combined as halt");
        ialm = !ext;
        drive({1'b0, ext, 3'h1});
        ialm = 1'b0;
        drive(5'h01);
        chk({2'h0, ealm, alm}, {2'h0, ext, 1'b1}, "alarm raised");
        seq(5'h03);
        chk({2'h0, ealm, alm}, {2'h0, ext, 1'b1}, "clear while run");
        seq(5'h01);
        chk({2'h0, ealm, alm}, 4'h0, "alarm cleared");
        $display("t_alarm done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        t_reset();
        t_single();
        t_dual();
        t_index();
        t_halt();
        t_alarm(FN_ALMCLR, 1'b1);
        t_alarm(FN_COMBINED, 1'b0);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(negedge mclk);
        failures++;
        report_and_stop();
    end
endmodule
bind mifc_top mifc_checker #(.CLR_HOLD(CLR_HOLD)) chk_u (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_pins(i_pins), .i_open_active(i_open_active), .i_func_codes(i_func_codes),
    .o_power(o_power), .o_run(o_run), .o_servo_wait(o_servo_wait), .o_alarm(o_alarm),
    .o_ext_alarm(o_ext_alarm), .o_data_index(o_data_index));
`default_nettype wire
